/* src/set_pkg.sv */
// Package for the two-wire serial EEPROM target: sizes, codes, timing and states.
// Assumes a 10 MHz reference clock and a free-running link sampling clock.
package set_pkg;
    localparam int ADDR_W_32K = 12;
    localparam int ADDR_W_64K = 13;
    localparam int PAGE_OFS_W = 5;
    localparam int PAGE_BYTES = 32;
    localparam int BYTE_W = 8;
    localparam int STRAP_W = 3;
    localparam int TYPE_W = 4;
    localparam int BIT_CNT_W = 4;
    localparam logic [BIT_CNT_W-1:0] BITS_PER_WORD = 4'h8;
    localparam logic [BIT_CNT_W-1:0] BIT_CNT_RST = 4'h0;
    // Arbitrary neutral value for the memory-type code.
    localparam logic [TYPE_W-1:0] TYPE_CODE_DEFAULT = 4'h6;
    localparam logic SDA_RELEASE = 1'b1;
    localparam logic [PAGE_BYTES-1:0] MASK_RST = 32'h0000_0000;
    localparam int PROG_TIME_MS = 5;
    localparam int REF_CLK_PERIOD_NS = 100;
    localparam int PROG_CYCLES = PROG_TIME_MS * 1000000 / REF_CLK_PERIOD_NS;
    localparam int CNT_W = 32;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_DEV  = 6'h02,
        ST_AHI  = 6'h04,
        ST_ALO  = 6'h08,
        ST_WDAT = 6'h10,
        ST_RDAT = 6'h20
    } set_state_t;
endpackage

/* src/set_eeprom_target.sv */
// Two-wire serial EEPROM target: bus front end, addressing, page buffer, array and self-timed programming.
// Assumes a free-running link clock much faster than the serial clock, and an external pull-up on the data line.
// Contract
// - Smaller variant: 128 pages of 32 bytes, 12-bit word address.
// - Larger variant: 256 pages of 32 bytes, 13-bit word address.
// - Data changes only while clock low; high-clock transitions are conditions.
// - Data falling while clock high is start; begins a new transfer.
// - Data rising while clock high is stop; ends current transfer.
// - Stop ending a read returns the device to standby.
// - Words are 8 bits; device acknowledges low in ninth clock.
// - Sample bits on rising clock, change output bits on falling clock.
// - Device only pulls data low or releases it.
// - Host sends 8-bit device address word right after each start.
// - Top four address-word bits must equal the memory-type code.
// - Next three bits must match the three chip-select straps.
// - Lowest address-word bit: high reads, low writes.
// - Match acknowledges; mismatch gives no acknowledge and returns to standby.
// - Write-protect high protects the whole array against writes.
// - Write-protect low allows normal reads and writes.
// - Standby at power-up and after stop once internal operations finish.
// - Recovery: host clocks, then start; device resynchronises on that start.
// - Write sequence end starts self-timed programming of at most 5 ms.
// - Accept page writes up to 32 bytes, and partial pages.
// - Page write increments only low five address bits, wrapping in page.
// - During programming, ignore inputs and do not acknowledge the address.
// - Address counter holds last address plus one; current read uses it.
// - Host acknowledge advances read address, wrapping array end to zero.
`timescale 1ns/1ps
module set_eeprom_target #(
    parameter int ADDR_W = set_pkg::ADDR_W_32K,
    parameter logic [set_pkg::TYPE_W-1:0] TYPE_CODE = set_pkg::TYPE_CODE_DEFAULT,
    parameter int PROG_CYCLES = set_pkg::PROG_CYCLES
) (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic link_clk_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    input wire logic chip_select_strap_2_i,
    input wire logic chip_select_strap_1_i,
    input wire logic chip_select_strap_0_i,
    input wire logic write_protect_i,
    output logic standby_o,
    output logic prog_busy_o
);
    localparam int OW = set_pkg::PAGE_OFS_W;
    localparam int CW = set_pkg::CNT_W;
    localparam int WORDS = 1 << ADDR_W;
    localparam logic [CW-1:0] PROG_LAST = CW'(PROG_CYCLES - 1);

    // Link-domain reset: asserts at once, releases on the link clock.
    logic [1:0] link_rst_reg;
    logic link_rst;
    always_ff @(posedge link_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            link_rst_reg <= 2'h3;
        end else begin
            link_rst_reg <= {link_rst_reg[0], 1'b0};
        end
    end
    assign link_rst = link_rst_reg[1];

    // Pin synchronisers; the third stage only feeds edge detection.
    logic scl_meta, scl_s, scl_q, sda_meta, sda_s, sda_q;
    logic wp_meta, wp_s, busy_meta, busy_s;
    logic [2:0] strap_meta, strap_s;
    always_ff @(posedge link_clk_i or posedge link_rst) begin
        if (link_rst) begin
            scl_meta <= 1'b1;
            scl_s <= 1'b1;
            scl_q <= 1'b1;
            sda_meta <= 1'b1;
            sda_s <= 1'b1;
            sda_q <= 1'b1;
            wp_meta <= 1'b1;
            wp_s <= 1'b1;
            strap_meta <= 3'h0;
            strap_s <= 3'h0;
        end else begin
            scl_meta <= scl_i;
            scl_s <= scl_meta;
            scl_q <= scl_s;
            sda_meta <= sda_i;
            sda_s <= sda_meta;
            sda_q <= sda_s;
            wp_meta <= write_protect_i;
            wp_s <= wp_meta;
            strap_meta <= {chip_select_strap_2_i, chip_select_strap_1_i, chip_select_strap_0_i};
            strap_s <= strap_meta;
        end
    end

    logic scl_rise, scl_fall, start_evt, stop_evt;
    assign scl_rise = scl_s & ~scl_q;
    assign scl_fall = ~scl_s & scl_q;
    assign start_evt = scl_s & scl_q & sda_q & ~sda_s;
    assign stop_evt = scl_s & scl_q & ~sda_q & sda_s;

    set_pkg::set_state_t state_reg;
    logic [set_pkg::BIT_CNT_W-1:0] bit_cnt_reg;
    logic [7:0] rx_sh_reg, tx_sh_reg, addr_hi_reg;
    logic ack_phase_reg, dir_rd_reg, host_ack_reg, sda_oe_n_reg;
    logic [ADDR_W-1:0] addr_cnt_reg;
    logic [7:0] mem [WORDS];
    logic [7:0] page_buf [set_pkg::PAGE_BYTES];
    logic [set_pkg::PAGE_BYTES-1:0] mask_reg;
    logic wr_any_reg, commit_reg, prog_wait_reg, busy_seen_reg, req_tgl_reg, standby_reg;
    logic [OW-1:0] commit_idx_reg;
    logic busy_link, rx_state, byte_end, ack_end, dev_match, ld_evt, commit_go;

    assign busy_link = commit_reg | prog_wait_reg;
    assign rx_state = (state_reg == set_pkg::ST_DEV) || (state_reg == set_pkg::ST_AHI) ||
        (state_reg == set_pkg::ST_ALO) || (state_reg == set_pkg::ST_WDAT);
    assign byte_end = scl_fall && !ack_phase_reg && rx_state && (bit_cnt_reg == set_pkg::BITS_PER_WORD);
    assign ack_end = scl_fall && ack_phase_reg;
    // Busy makes the compare fail, so polling sees no acknowledge.
    assign dev_match = (rx_sh_reg[7:4] == TYPE_CODE) && (rx_sh_reg[3:1] == strap_s) && !busy_link;
    assign ld_evt = ack_end && (((state_reg == set_pkg::ST_DEV) && dir_rd_reg) ||
        ((state_reg == set_pkg::ST_RDAT) && host_ack_reg));
    assign commit_go = stop_evt && wr_any_reg && !wp_s;

    // Protocol sequencing: states, bit counting and shifting.
    always_ff @(posedge link_clk_i or posedge link_rst) begin
        if (link_rst) begin
            state_reg <= set_pkg::ST_IDLE;
            bit_cnt_reg <= set_pkg::BIT_CNT_RST;
            rx_sh_reg <= 8'h00;
            ack_phase_reg <= 1'b0;
            dir_rd_reg <= 1'b0;
            host_ack_reg <= 1'b0;
        end else if (start_evt) begin
            state_reg <= set_pkg::ST_DEV;
            bit_cnt_reg <= set_pkg::BIT_CNT_RST;
            ack_phase_reg <= 1'b0;
        end else if (stop_evt) begin
            state_reg <= set_pkg::ST_IDLE;
            ack_phase_reg <= 1'b0;
        end else if (state_reg != set_pkg::ST_IDLE) begin
            if (scl_rise && !ack_phase_reg) begin
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                if (rx_state) begin
                    rx_sh_reg <= {rx_sh_reg[6:0], sda_s};
                end
            end else if (scl_rise && (state_reg == set_pkg::ST_RDAT)) begin
                host_ack_reg <= ~sda_s;
            end
            if (byte_end) begin
                if (state_reg == set_pkg::ST_DEV && !dev_match) begin
                    state_reg <= set_pkg::ST_IDLE;
                end else begin
                    ack_phase_reg <= 1'b1;
                end
                if (state_reg == set_pkg::ST_DEV) begin
                    dir_rd_reg <= rx_sh_reg[0];
                end
            end else if (scl_fall && !ack_phase_reg && (state_reg == set_pkg::ST_RDAT) &&
                (bit_cnt_reg == set_pkg::BITS_PER_WORD)) begin
                ack_phase_reg <= 1'b1;
            end else if (ack_end) begin
                ack_phase_reg <= 1'b0;
                bit_cnt_reg <= set_pkg::BIT_CNT_RST;
                unique case (state_reg)
                    set_pkg::ST_DEV: state_reg <= dir_rd_reg ? set_pkg::ST_RDAT : set_pkg::ST_AHI;
                    set_pkg::ST_AHI: state_reg <= set_pkg::ST_ALO;
                    set_pkg::ST_ALO: state_reg <= set_pkg::ST_WDAT;
                    set_pkg::ST_WDAT: state_reg <= set_pkg::ST_WDAT;
                    set_pkg::ST_RDAT: state_reg <= host_ack_reg ? set_pkg::ST_RDAT : set_pkg::ST_IDLE;
                    set_pkg::ST_IDLE: state_reg <= set_pkg::ST_IDLE;
                endcase
            end
        end
    end

    // Open-drain drive; changes happen only on falling clock edges.
    always_ff @(posedge link_clk_i or posedge link_rst) begin
        if (link_rst) begin
            sda_oe_n_reg <= set_pkg::SDA_RELEASE;
            tx_sh_reg <= 8'h00;
        end else if (start_evt || stop_evt) begin
            sda_oe_n_reg <= set_pkg::SDA_RELEASE;
        end else if (byte_end) begin
            sda_oe_n_reg <= !((state_reg != set_pkg::ST_DEV) || dev_match);
        end else if (ld_evt) begin
            tx_sh_reg <= mem[addr_cnt_reg];
            sda_oe_n_reg <= mem[addr_cnt_reg][7];
        end else if (ack_end) begin
            sda_oe_n_reg <= set_pkg::SDA_RELEASE;
        end else if (scl_fall && (state_reg == set_pkg::ST_RDAT) && !ack_phase_reg) begin
            if (bit_cnt_reg == set_pkg::BITS_PER_WORD) begin
                sda_oe_n_reg <= set_pkg::SDA_RELEASE;
            end else begin
                tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
                sda_oe_n_reg <= tx_sh_reg[6];
            end
        end
    end
    assign sda_o = 1'b0;
    assign sda_oe_n_o = sda_oe_n_reg;

    // Word address counter.
    always_ff @(posedge link_clk_i or posedge link_rst) begin
        if (link_rst) begin
            addr_cnt_reg <= '0;
            addr_hi_reg <= 8'h00;
        end else if (byte_end && state_reg == set_pkg::ST_AHI) begin
            addr_hi_reg <= rx_sh_reg;
        end else if (byte_end && state_reg == set_pkg::ST_ALO) begin
            addr_cnt_reg <= ADDR_W'({addr_hi_reg, rx_sh_reg});
        end else if (byte_end && state_reg == set_pkg::ST_WDAT) begin
            addr_cnt_reg[OW-1:0] <= OW'(addr_cnt_reg[OW-1:0] + 1'b1);
        end else if (ld_evt) begin
            addr_cnt_reg <= ADDR_W'(addr_cnt_reg + 1'b1);
        end
    end

    // Page buffer collects data bytes until the stop.
    always_ff @(posedge link_clk_i or posedge link_rst) begin
        if (link_rst) begin
            mask_reg <= set_pkg::MASK_RST;
            wr_any_reg <= 1'b0;
        end else if (start_evt || stop_evt) begin
            mask_reg <= set_pkg::MASK_RST;
            wr_any_reg <= 1'b0;
        end else if (byte_end && state_reg == set_pkg::ST_WDAT) begin
            mask_reg[addr_cnt_reg[OW-1:0]] <= 1'b1;
            wr_any_reg <= 1'b1;
        end
    end
    always_ff @(posedge link_clk_i) begin
        if (byte_end && state_reg == set_pkg::ST_WDAT) begin
            page_buf[addr_cnt_reg[OW-1:0]] <= rx_sh_reg;
        end
    end

    // Commit walks the page one byte per link cycle to keep the array single-ported.
    logic [set_pkg::PAGE_BYTES-1:0] commit_mask_reg;
    always_ff @(posedge link_clk_i or posedge link_rst) begin
        if (link_rst) begin
            commit_reg <= 1'b0;
            commit_idx_reg <= '0;
            commit_mask_reg <= set_pkg::MASK_RST;
        end else if (commit_go) begin
            commit_reg <= 1'b1;
            commit_idx_reg <= '0;
            commit_mask_reg <= mask_reg;
        end else if (commit_reg) begin
            commit_idx_reg <= OW'(commit_idx_reg + 1'b1);
            commit_reg <= (commit_idx_reg != {OW{1'b1}});
        end
    end
    always_ff @(posedge link_clk_i) begin
        if (commit_reg && commit_mask_reg[commit_idx_reg]) begin
            mem[{addr_cnt_reg[ADDR_W-1:OW], commit_idx_reg}] <= page_buf[commit_idx_reg];
        end
    end

    // Programming wait: held until the reference-domain timer rises and falls again.
    always_ff @(posedge link_clk_i or posedge link_rst) begin
        if (link_rst) begin
            req_tgl_reg <= 1'b0;
            prog_wait_reg <= 1'b0;
            busy_seen_reg <= 1'b0;
            busy_meta <= 1'b0;
            busy_s <= 1'b0;
            standby_reg <= 1'b1;
        end else begin
            busy_meta <= prog_busy_o;
            busy_s <= busy_meta;
            standby_reg <= (state_reg == set_pkg::ST_IDLE) && !busy_link && !commit_go;
            if (commit_go) begin
                req_tgl_reg <= ~req_tgl_reg;
                prog_wait_reg <= 1'b1;
                busy_seen_reg <= 1'b0;
            end else if (prog_wait_reg && busy_s) begin
                busy_seen_reg <= 1'b1;
            end else if (prog_wait_reg && busy_seen_reg && !busy_s) begin
                prog_wait_reg <= 1'b0;
            end
        end
    end
    assign standby_o = standby_reg;

    // Self-timed programming timer on the reference clock.
    logic req_meta, req_s, req_q, prog_busy_reg;
    logic [CW-1:0] prog_cnt_reg;
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            req_meta <= 1'b0;
            req_s <= 1'b0;
            req_q <= 1'b0;
            prog_busy_reg <= 1'b0;
            prog_cnt_reg <= '0;
        end else begin
            req_meta <= req_tgl_reg;
            req_s <= req_meta;
            req_q <= req_s;
            if (req_s != req_q) begin
                prog_busy_reg <= 1'b1;
                prog_cnt_reg <= '0;
            end else if (prog_busy_reg) begin
                prog_cnt_reg <= CW'(prog_cnt_reg + 1'b1);
                prog_busy_reg <= (prog_cnt_reg != PROG_LAST);
            end
        end
    end
    assign prog_busy_o = prog_busy_reg;

    sequence s_dev_byte_end;
        byte_end && (state_reg == set_pkg::ST_DEV);
    endsequence
    sequence s_write_stop;
        stop_evt && wr_any_reg;
    endsequence

    chk_sda_only_low: assert property (@(posedge link_clk_i) disable iff (link_rst)
        (sda_o == 1'b0) && (sda_oe_n_reg || ack_phase_reg || (state_reg == set_pkg::ST_RDAT)))
        else $error("data line driven outside acknowledge or read data");
    chk_start_resync: assert property (@(posedge link_clk_i) disable iff (link_rst)
        start_evt |=> (state_reg == set_pkg::ST_DEV) && (bit_cnt_reg == set_pkg::BIT_CNT_RST))
        else $error("start did not begin address phase");
    chk_stop_idle: assert property (@(posedge link_clk_i) disable iff (link_rst)
        stop_evt |=> (state_reg == set_pkg::ST_IDLE) && sda_oe_n_reg)
        else $error("stop did not end transfer");
    chk_addr_ack: assert property (@(posedge link_clk_i) disable iff (link_rst)
        (s_dev_byte_end and dev_match) |=> !sda_oe_n_reg && ack_phase_reg)
        else $error("matching address not acknowledged");
    chk_busy_no_ack: assert property (@(posedge link_clk_i) disable iff (link_rst)
        (s_dev_byte_end and busy_link) |=> sda_oe_n_reg && (state_reg == set_pkg::ST_IDLE))
        else $error("address acknowledged while programming");
    chk_protect_commit: assert property (@(posedge link_clk_i) disable iff (link_rst)
        (s_write_stop and wp_s) |=> !commit_reg && !prog_wait_reg)
        else $error("protected write started programming");
    chk_write_commit: assert property (@(posedge link_clk_i) disable iff (link_rst)
        (s_write_stop and !wp_s and !commit_reg) |=> commit_reg && prog_wait_reg && $changed(req_tgl_reg))
        else $error("write did not start programming");
    chk_page_wrap: assert property (@(posedge link_clk_i) disable iff (link_rst)
        (byte_end && state_reg == set_pkg::ST_WDAT) |=>
        (addr_cnt_reg[OW-1:0] == OW'($past(addr_cnt_reg[OW-1:0]) + 1'b1)) &&
        (addr_cnt_reg[ADDR_W-1:OW] == $past(addr_cnt_reg[ADDR_W-1:OW])))
        else $error("page address did not wrap in page");
    chk_read_advance: assert property (@(posedge link_clk_i) disable iff (link_rst)
        ld_evt |=> addr_cnt_reg == ADDR_W'($past(addr_cnt_reg) + 1'b1))
        else $error("read address did not advance");
    chk_edge_on_fall: assert property (@(posedge link_clk_i) disable iff (link_rst)
        $changed(sda_oe_n_reg) |-> !scl_s)
        else $error("data line changed with clock high");
    chk_prog_length: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (prog_busy_reg && prog_cnt_reg == PROG_LAST) |=> !prog_busy_reg)
        else $error("programming outlasted its time");
endmodule

/* sim/set_host_model.sv */
// Host controller model for the two-wire bus: drives the serial clock and pulls the data line low.
// Assumes the bench resolves the wire with a pull-up and that clk_i is the 10 MHz reference clock.
`timescale 1ns/1ps
module set_host_model (
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o
);
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    task automatic step();
        @(posedge clk_i);
        #1;
    endtask
    // Each phase spans two steps, far above the three link cycles the target needs.
    task automatic bit_io(input logic b, output logic r);
        sda_low_o = !b;
        step();
        scl_o = 1'b1;
        step();
        r = sda_i;
        step();
        scl_o = 1'b0;
        step();
    endtask
    task automatic start();
        sda_low_o = 1'b0;
        step();
        scl_o = 1'b1;
        step();
        sda_low_o = 1'b1;
        step();
        scl_o = 1'b0;
        step();
    endtask
    task automatic stop();
        sda_low_o = 1'b1;
        step();
        scl_o = 1'b1;
        step();
        sda_low_o = 1'b0;
        step();
        step();
    endtask
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = !r;
    endtask
    task automatic rd_byte(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(!more, r);
    endtask
    // Nine released clocks let a target caught mid-way through a read byte finish and see a missing acknowledge.
    task automatic recover();
        logic r;
        for (int i = 0; i < 9; i++) begin
            bit_io(1'b1, r);
        end
    endtask
endmodule

/* sim/tb_serial_eeprom_two_wire_target.sv */
// Self-checking bench for the two-wire EEPROM target with a shadow memory and random traffic.
// Assumes the design carries its own assertions; this file judges behaviour at the ports.
`timescale 1ns/1ps
module tb_serial_eeprom_two_wire_target;
    localparam int PROG = 200;
    localparam logic [3:0] TC = 4'h6; // Arbitrary memory-type code, not a real family value.
    logic ref_clk_i, link_clk, rst, scl, host_low, sda, sda_o, oe_n, standby, busy, wp;
    logic [2:0] strap;
    logic [31:0] seed = 32'h0000_0033;
    logic [7:0] mem [int];
    logic [11:0] cnt, wa;
    int mismatches = 0;
    int n_tests = 0;
    int busy_cnt = 0;
    initial begin
        ref_clk_i = 1'b0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end
    initial begin
        link_clk = 1'b0;
        #3.7;
        forever #6 link_clk = ~link_clk;
    end
    assign sda = (host_low || (!oe_n && !sda_o)) ? 1'b0 : 1'b1;
    always @(posedge ref_clk_i) if (busy === 1'b1) busy_cnt++;
    set_eeprom_target #(.ADDR_W(12), .TYPE_CODE(TC), .PROG_CYCLES(PROG)) u_set_eeprom_target (
        .ref_clk_i(ref_clk_i), .sys_rst_i(rst), .link_clk_i(link_clk), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe_n_o(oe_n), .chip_select_strap_2_i(strap[2]),
        .chip_select_strap_1_i(strap[1]), .chip_select_strap_0_i(strap[0]),
        .write_protect_i(wp), .standby_o(standby), .prog_busy_o(busy));
    set_host_model u_set_host_model (.clk_i(ref_clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(host_low));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] dev(logic rw);
        return {TC, strap, rw};
    endfunction
    task automatic chk1(logic g, logic e);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %0t flag got %b exp %b", $time, g, e);
        end
    endtask
    task automatic chk8(logic [7:0] g, logic [7:0] e);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %0t byte got %h exp %h", $time, g, e);
        end
    endtask
    task automatic close_out();
        if (mismatches == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic send(logic [7:0] d, logic exp_ack);
        logic ack;
        u_set_host_model.wr_byte(d, ack);
        chk1(ack, exp_ack);
    endtask
    task automatic do_write(logic [11:0] a, int n);
        logic ack;
        logic [4:0] o;
        logic [7:0] d;
        int polls;
        o = a[4:0];
        busy_cnt = 0;
        polls = 0;
        ack = 1'b0;
        u_set_host_model.start();
        send(dev(1'b0), 1'b1);
        send({4'(rnd()), a[11:8]}, 1'b1);
        send(a[7:0], 1'b1);
        for (int i = 0; i < n; i++) begin
            d = 8'(rnd());
            send(d, 1'b1);
            if (!wp) mem[int'({a[11:5], o})] = d;
            o++;
        end
        u_set_host_model.stop();
        cnt = {a[11:5], o};
        if (wp) begin
            repeat (40) u_set_host_model.step();
            chk1(busy_cnt != 0, 1'b0);
            chk1(standby, 1'b1);
        end else begin
            chk1(standby, 1'b0);
            // A write-direction poll with no data ends without a commit.
            while (!ack && polls < 100) begin
                u_set_host_model.start();
                u_set_host_model.wr_byte(dev(1'b0), ack);
                u_set_host_model.stop();
                polls++;
            end
            chk1(polls > 1 && ack, 1'b1);
            chk1(busy_cnt inside {[PROG:PROG + 1]}, 1'b1);
        end
    endtask
    task automatic do_read(logic [11:0] a, int n, logic ra);
        logic [7:0] d;
        if (ra) begin
            u_set_host_model.start();
            send(dev(1'b0), 1'b1);
            send({4'h0, a[11:8]}, 1'b1);
            send(a[7:0], 1'b1);
            cnt = a;
        end
        u_set_host_model.start();
        send(dev(1'b1), 1'b1);
        for (int i = 0; i < n; i++) begin
            u_set_host_model.rd_byte(i < n - 1, d);
            if (mem.exists(int'(cnt))) chk8(d, mem[int'(cnt)]);
            cnt++;
        end
        u_set_host_model.stop();
        chk1(standby, 1'b1);
    endtask
    initial begin
        #5000000;
        mismatches++;
        close_out();
    end
    initial begin
        logic r;
        rst = 1'b1;
        wp = 1'b0;
        strap = 3'(rnd());
        repeat (4) @(posedge ref_clk_i);
        #1;
        rst = 1'b0;
        repeat (3) u_set_host_model.step();
        chk1(standby, 1'b1);
        chk1(busy, 1'b0);
        chk1(oe_n, 1'b1);
        for (int i = 1; i < 8; i++) begin
            u_set_host_model.start();
            send(dev(1'b0) ^ 8'(1 << i), 1'b0);
            u_set_host_model.stop();
            chk1(standby, 1'b1);
        end
        do_write(12'(rnd()), 35);
        do_read(12'h000, 2, 1'b0);
        repeat (4) begin
            wa = 12'(rnd());
            do_write(wa, int'(rnd() % 32'd8) + 1);
            do_read(wa, 3, 1'b1);
        end
        do_write(12'hfff, 1);
        do_write(12'h000, 1);
        do_read(12'hfff, 2, 1'b1);
        wp = 1'b1;
        do_write(12'hfff, 3);
        wp = 1'b0;
        do_read(12'hfff, 2, 1'b1);
        u_set_host_model.start();
        send(dev(1'b1), 1'b1);
        repeat (3) u_set_host_model.bit_io(1'b1, r);
        u_set_host_model.recover();
        do_read(12'h000, 1, 1'b1);
        close_out();
    end
endmodule
